//--- mtp_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// two flop pin synchroniser with polarity-selected edge detect
// ------------------------------------------------------------
module mtp_edge_sync (
    input  wire logic mclk_i,      // system clock
    input  wire logic resetn_i,    // async reset, active low
    input  wire logic pin_i,       // asynchronous timer input pin
    input  wire logic fall_sel_i,  // 1 selects falling edges
    output logic      edge_o       // one-cycle pulse on selected edge
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // first stage is read only by the second stage
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edge qualified by the polarity choice
    always_comb begin
        edge_o = fall_sel_i ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff);
    end

endmodule

`default_nettype wire

//--- mtp_pkg.sv
package mtp_pkg;

    // ------------------------------------------------------------
    // mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MTP_CONTINUOUS,
        MTP_COUNTER,
        MTP_PWM,
        MTP_CAPTURE
    } mtp_mode_t;

    // ------------------------------------------------------------
    // widths, reset values and counts
    // ------------------------------------------------------------
    localparam int              MTP_CNT_W      = 16;
    localparam int              MTP_PRE_W      = 3;
    localparam logic [15:0]     MTP_CNT_ONE    = 16'h0001;
    localparam logic [15:0]     MTP_CNT_RST    = 16'h0001;
    localparam logic [15:0]     MTP_RELOAD_RST = 16'hFFFF;
    localparam logic [15:0]     MTP_PWM_RST    = 16'h0000;
    localparam logic [6:0]      MTP_PRE_RST    = 7'h00;
    localparam int              MTP_SYNC_STAGES = 2;
    localparam int              MTP_CLK_HZ     = 25000000;

endpackage

//--- mtp_src.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// external source driving the timer input pin
// ------------------------------------------------------------
module mtp_src (
    input  wire logic mclk_i, // system clock
    output logic      pin_o   // timer input pin level
);
    initial pin_o = 1'b0;

    // three cycles per level keeps the pin at a sixth of mclk, below a quarter
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (3) @(negedge mclk_i);
            pin_o = ~pin_o;
        end
        repeat (3) @(negedge mclk_i);
    endtask
endmodule

`default_nettype wire

//--- mtp_timer.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - continuous mode counts system clock through the prescaler; period reload times prescale
// - counter mode counts timer input edges with prescaler bypassed
// - polarity bit picks rising or falling edges counted in counter mode
// - counter mode at reload raises interrupt, count returns to one, keeps counting
// - with output enabled, output pin toggles at every reload
// - polarity written during configuration sets initial output level even if disabled
// - software starting count affects only first pass; later passes start from one
// - pwm period is reload times prescale over system clock
// - polarity 0 high time reload minus pwm; polarity 1 high time pwm
// - a starting count other than one shortens or lengthens first period
// - capture mode copies current count into capture value on selected edge
// - polarity bit picks rising or falling edge that triggers capture
// - capture raises interrupt and counting continues without reset
// - capture mode counts to reload, raises interrupt and continues

module mtp_timer (
    input  wire logic        mclk_i,        // system clock, 25 MHz
    input  wire logic        resetn_i,      // async reset, active low
    input  wire logic        enable_i,      // timer run enable
    input  wire logic [1:0]  mode_i,        // mtp_mode_t encoding
    input  wire logic        timer_polarity_select_i, // edge and level polarity
    input  wire logic [2:0]  prescale_i,    // prescale = 2**prescale_i
    input  wire logic        out_en_i,      // timer output alternate function on
    input  wire logic [15:0] reload_i,      // reload value
    input  wire logic [15:0] pwm_i,         // pwm compare value
    input  wire logic        cnt_wr_i,      // load count pulse
    input  wire logic [15:0] cnt_wdata_i,   // count write data
    input  wire logic        timer_in_i,    // timer input pin, asynchronous
    output logic [15:0]      count_o,       // current count
    output logic [15:0]      capture_o,     // captured count value
    output logic             irq_o,         // one-cycle interrupt pulse
    output logic             timer_out_o,   // timer output pin level
    output logic             timer_out_oe_o // output enable, high while driving
);

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] cap_ff;
    logic [6:0]  pre_ff;
    logic        irq_ff;
    logic        out_ff;
    logic        oe_ff;
    logic        pin_edge;
    logic        tick;
    logic        at_reload;
    mtp_pkg::mtp_mode_t mode;

    assign mode = mtp_pkg::mtp_mode_t'(mode_i);

    // ------------------------------------------------------------
    // input pin synchroniser and edge select
    // ------------------------------------------------------------
    mtp_edge_sync u_sync (
        .mclk_i     (mclk_i),
        .resetn_i   (resetn_i),
        .pin_i      (timer_in_i),
        .fall_sel_i (timer_polarity_select_i),
        .edge_o     (pin_edge)
    );

    // prescale terminal test, shared by tick and next-state logic
    function automatic logic pre_done(input logic [6:0] p, input logic [2:0] sel);
        logic [6:0] lim;
        lim = 7'((8'h01 << sel) - 8'h01);
        return p == lim;
    endfunction

    // ------------------------------------------------------------
    // prescaler; held at zero while stopped so each run starts clean
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_ff <= mtp_pkg::MTP_PRE_RST;
        end else if (!enable_i || mode == mtp_pkg::MTP_COUNTER) begin
            pre_ff <= mtp_pkg::MTP_PRE_RST;
        end else if (pre_done(pre_ff, prescale_i)) begin
            pre_ff <= mtp_pkg::MTP_PRE_RST;
        end else begin
            pre_ff <= pre_ff + 7'h01;
        end
    end

    // count source: pin edges in counter mode, prescaled clock otherwise
    always_comb begin
        if (mode == mtp_pkg::MTP_COUNTER) begin
            tick = enable_i & pin_edge;
        end else begin
            tick = enable_i & pre_done(pre_ff, prescale_i);
        end
        at_reload = tick && (cnt_ff == reload_i);
    end

    // next count: reload wraps to one, never to the software start value
    always_comb begin
        nxt_cnt = cnt_ff;
        if (at_reload) begin
            nxt_cnt = mtp_pkg::MTP_CNT_ONE;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // counter; software load wins over counting
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= mtp_pkg::MTP_CNT_RST;
        end else if (cnt_wr_i) begin
            cnt_ff <= cnt_wdata_i;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // capture keeps running count untouched
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_ff <= mtp_pkg::MTP_PWM_RST;
        end else if (enable_i && mode == mtp_pkg::MTP_CAPTURE && pin_edge) begin
            cap_ff <= cnt_ff;
        end
    end

    // interrupt pulse on reload and on capture
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= at_reload ||
                      (enable_i && mode == mtp_pkg::MTP_CAPTURE && pin_edge);
        end
    end

    // ------------------------------------------------------------
    // output level; while stopped it follows polarity so a
    // configuration write presets it even with output disabled
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_ff <= 1'b0;
        end else if (!enable_i) begin
            out_ff <= timer_polarity_select_i;
        end else if (mode == mtp_pkg::MTP_PWM) begin
            if (at_reload) begin
                out_ff <= timer_polarity_select_i;
            end else if (tick && cnt_ff == pwm_i) begin
                out_ff <= ~timer_polarity_select_i;
            end
        end else if (at_reload) begin
            out_ff <= ~out_ff;
        end
    end

    // pin only driven when the alternate function is chosen
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= out_en_i;
        end
    end

    assign count_o        = cnt_ff;
    assign capture_o      = cap_ff;
    assign irq_o          = irq_ff;
    assign timer_out_o    = out_ff;
    assign timer_out_oe_o = oe_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    a_reload_wraps_one: assert property (
        (at_reload && !cnt_wr_i) |=> cnt_ff == 16'h0001)
        else $error("count did not wrap to one at reload");
    a_reload_irq: assert property (
        at_reload |=> irq_o)
        else $error("no interrupt after reload");
    a_capture_copy: assert property (
        (enable_i && mode == mtp_pkg::MTP_CAPTURE && pin_edge) |=> capture_o == $past(cnt_ff))
        else $error("capture value not the count");
    a_capture_no_reset: assert property (
        (enable_i && mode == mtp_pkg::MTP_CAPTURE && pin_edge && !at_reload && !cnt_wr_i)
        |=> (cnt_ff == $past(cnt_ff)) || (cnt_ff == $past(cnt_ff) + 16'h0001))
        else $error("capture disturbed the count");
    a_counter_no_edge: assert property (
        (mode == mtp_pkg::MTP_COUNTER && !pin_edge && !cnt_wr_i) |=> $stable(cnt_ff))
        else $error("counter mode moved without an edge");
    a_output_toggle: assert property (
        (enable_i && mode != mtp_pkg::MTP_PWM && at_reload) |=> timer_out_o != $past(timer_out_o))
        else $error("output did not toggle at reload");
    a_stopped_level: assert property (
        !enable_i |=> timer_out_o == $past(timer_polarity_select_i))
        else $error("stopped output level not polarity");
    a_pwm_match: assert property (
        (enable_i && mode == mtp_pkg::MTP_PWM && tick && cnt_ff == pwm_i && !at_reload)
        |=> timer_out_o == !$past(timer_polarity_select_i))
        else $error("pwm output wrong after match");
    a_prescale_gap: assert property (
        (enable_i && mode == mtp_pkg::MTP_CONTINUOUS && prescale_i == 3'h1 && tick)
        |=> !tick)
        else $error("prescaler ticked too early");

    c_reload: cover property (at_reload);
    c_capture: cover property (mode == mtp_pkg::MTP_CAPTURE && pin_edge && enable_i);
    c_pwm_cycle: cover property (mode == mtp_pkg::MTP_PWM && tick && cnt_ff == pwm_i ##[1:50] at_reload);

endmodule

`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// self-checking bench for the multimode timer
// ------------------------------------------------------------
module testbench;
    logic        mclk, resetn, en, pol, oen, cwr, irq, tout, toe, pin;
    logic [1:0]  mode;
    logic [2:0]  pre;
    logic [15:0] rld, pwm, cwd, count, cap;
    logic [31:0] seed = 32'h0000_0007;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_irq = 0;
    int          n_hi = 0;

    mtp_timer uut (.mclk_i(mclk), .resetn_i(resetn), .enable_i(en), .mode_i(mode),
        .timer_polarity_select_i(pol), .prescale_i(pre), .out_en_i(oen), .reload_i(rld),
        .pwm_i(pwm), .cnt_wr_i(cwr), .cnt_wdata_i(cwd), .timer_in_i(pin), .count_o(count),
        .capture_o(cap), .irq_o(irq), .timer_out_o(tout), .timer_out_oe_o(toe));
    mtp_src src (.mclk_i(mclk), .pin_o(pin));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // running tallies; windows take differences so no clearing race
    always @(posedge mclk) begin
        n_irq += (irq === 1'b1);
        n_hi += (tout === 1'b1);
    end

    function automatic logic [15:0] rnd(input int span);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 16'(seed % span);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // stop, load everything, then enable last as software would
    task automatic cfg(input logic [1:0] m, input logic p, input logic [2:0] ps,
                       input logic [15:0] r, input logic [15:0] w, input logic [15:0] s);
        @(negedge mclk);
        en = 1'b0;
        mode = m;
        pol = p;
        pre = ps;
        pwm = w;
        rld = r;
        cwd = s;
        cwr = 1'b1;
        @(negedge mclk);
        cwr = 1'b0;
        en = 1'b1;
    endtask

    // two whole periods after an aligning interrupt: counts are phase free
    task automatic period_run(input logic [1:0] m);
        logic [15:0] r, w, hi;
        logic [2:0]  ps;
        logic        p;
        int          i, i0, h0, span;
        r = 16'd4 + rnd(8);
        w = 16'd1 + rnd(int'(r) - 1);
        ps = 3'(rnd(3));
        p = 1'(rnd(2));
        cfg(m, p, ps, r, w, 16'h0001);
        span = int'(r) << ps;
        for (i = 0; i < 2 * span + 8 && irq !== 1'b1; i++) @(negedge mclk);
        chk(count, 16'h0001);
        i0 = n_irq;
        h0 = n_hi;
        repeat (2 * span) @(negedge mclk);
        chk(16'(n_irq - i0), 16'h0002);
        hi = (m == 2'h0) ? 16'(span) : 16'(2 * (int'(p ? w : r - w) << ps));
        if (m != 2'h3) chk(16'(n_hi - h0), hi);
    endtask

    // prescale at its largest: a counter that used it would barely move
    task automatic cnt_run();
        logic [15:0] r, s, c;
        logic        p, lvl;
        int          n, k, i0, q;
        r = 16'd2 + rnd(6);
        s = 16'd1 + rnd(int'(r));
        n = 3 + int'(rnd(8));
        p = 1'(rnd(2));
        cfg(2'(mtp_pkg::MTP_COUNTER), p, 3'h7, r, 16'h0000, s);
        i0 = n_irq;
        lvl = pin;
        c = s;
        q = 0;
        for (k = 0; k < n; k++) begin
            lvl = ~lvl;
            if (lvl != p) begin
                if (c == r) begin
                    c = 16'h0001;
                    q++;
                end else c++;
            end
        end
        src.toggle(n);
        repeat (4) @(negedge mclk);
        chk(count, c);
        chk(16'(n_irq - i0), 16'(q));
    endtask

    // one pin change; only the selected direction may capture
    task automatic cap_run(input logic p);
        logic [15:0] c0, k0;
        logic        hit;
        int          i0;
        hit = (pin == p);
        c0 = count;
        k0 = cap;
        i0 = n_irq;
        src.toggle(1);
        repeat (4) @(negedge mclk);
        chk(count - c0, 16'h000A);
        chk(16'(n_irq - i0), 16'(hit));
        if (hit) begin
            chk(16'(cap > c0 + 16'h2 && cap < count), 16'h0001);
            chk(cap, c0 + 16'h0005);
        end else begin
            chk(cap, k0);
        end
    endtask

    initial begin
        resetn = 1'b0;
        en = 1'b0;
        mode = 2'h0;
        pol = 1'b0;
        pre = 3'h0;
        oen = 1'b0;
        rld = 16'hFFFF;
        pwm = 16'h0000;
        cwr = 1'b0;
        cwd = 16'h0000;
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        chk(count, 16'h0001);
        chk(cap, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            pol = 1'(p);
            oen = 1'(p);
            repeat (3) @(negedge mclk);
            chk(16'(tout), 16'(p));
            chk(16'(toe), 16'(p));
        end
        oen = 1'b1;
        repeat (3) begin
            period_run(2'(mtp_pkg::MTP_CONTINUOUS));
            period_run(2'(mtp_pkg::MTP_PWM));
            period_run(2'(mtp_pkg::MTP_CAPTURE));
        end
        repeat (6) cnt_run();
        for (int p = 0; p < 2; p++) begin
            cfg(2'(mtp_pkg::MTP_CAPTURE), 1'(p), 3'h0, 16'hFFFF, 16'h0000, 16'h0001);
            repeat (3) cap_run(1'(p));
        end
        results();
    end

    // whole run is under two thousand cycles; this is far beyond it
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
endmodule

`default_nettype wire
